// ---- inc/fieldbus_ctl_pkg.sv ----
package fieldbus_ctl_pkg;

  // Frame field values
  localparam logic [7:0]  FC_PRESET_SINGLE = 8'h06;
  localparam logic [7:0]  FC_PRESET_MULTI  = 8'h10;
  localparam logic [7:0]  BROADCAST_ADDR   = 8'h00;
  localparam logic [7:0]  MAX_MULTI_QTY    = 8'h7B;

  // Byte positions inside a query and its answer, and frame lengths
  localparam logic [7:0]  POS_ADDR_LO      = 8'h03;
  localparam logic [7:0]  POS_MULTI_DATA   = 8'h07;
  localparam logic [2:0]  POS_RESP_CRC_LO  = 3'h6;
  localparam logic [2:0]  POS_RESP_LAST    = 3'h7;
  localparam logic [7:0]  SINGLE_FRAME_LEN = 8'h08;
  localparam logic [8:0]  MULTI_FIXED_LEN  = 9'h009;
  localparam int          FRAME_BUF_DEPTH  = 8;

  // Register number of the command word; the wire carries number minus one
  localparam logic [15:0] CMD_REG_NUMBER   = 16'h0010;
  localparam logic [15:0] CMD_WIRE_ADDR    = CMD_REG_NUMBER - 16'h0001;
  localparam logic [15:0] CMD_WORD_RESET   = 16'h0000;

  // CRC-16 as used on the serial link, reflected form
  localparam logic [15:0] CRC_INIT         = 16'hFFFF;
  localparam logic [15:0] CRC_POLY         = 16'hA001;

  // Command word bit positions
  localparam int BIT_REF_LSB   = 0;
  localparam int BIT_REF_MSB   = 1;
  localparam int BIT_DC_BRAKE  = 2;
  localparam int BIT_COAST     = 3;
  localparam int BIT_QSTOP     = 4;
  localparam int BIT_HOLD      = 5;
  localparam int BIT_START     = 6;
  localparam int BIT_RESET     = 7;
  localparam int BIT_JOG       = 8;
  localparam int BIT_RAMP      = 9;
  localparam int BIT_VALID     = 10;
  localparam int BIT_RELAY1    = 11;
  localparam int BIT_RELAY2    = 12;
  localparam int BIT_SETUP     = 13;
  localparam int BIT_REVERSE   = 15;

  // Source selection codes for bus/input gating
  localparam logic [1:0] SRC_DIGITAL = 2'h0;
  localparam logic [1:0] SRC_BUS     = 2'h1;
  localparam logic [1:0] SRC_OR      = 2'h2;
  localparam logic [1:0] SRC_AND     = 2'h3;

  // Configuration option codes
  localparam logic [7:0] RELAY1_OPTION = 8'h24;
  localparam logic [7:0] RELAY2_OPTION = 8'h25;
  localparam logic [3:0] MULTI_SETUP   = 4'h9;

  // Digital input vector layout
  localparam int DIN_WIDTH      = 10;
  localparam int DIN_REF_LSB    = 0;
  localparam int DIN_REF_MSB    = 1;
  localparam int DIN_RUN_PERMIT = 2;
  localparam int DIN_START      = 3;
  localparam int DIN_SETUP      = 4;
  localparam int DIN_REVERSE    = 5;
  localparam int DIN_DC_BRAKE   = 6;
  localparam int DIN_COAST_STOP = 7;
  localparam int DIN_RST_COAST  = 8;
  localparam int DIN_SPARE      = 9;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RECV = 2'b01,
    ST_RESP = 2'b10
  } link_state_e;

endpackage

// ---- inc/crc_if.sv ----
`timescale 1ns/10ps
interface crc_if;
  logic        clear;
  logic        valid;
  logic [7:0]  data;
  logic [15:0] crc;

  modport user   (output clear, output valid, output data, input crc);
  modport engine (input clear, input valid, input data, output crc);
endinterface

// ---- verilog/crc16_engine.sv ----
`timescale 1ns/10ps
module crc16_engine (
  input wire logic clk_sys,
  input wire logic resetn,
  crc_if.engine    port
);
  import fieldbus_ctl_pkg::*;

  typedef struct packed {
    logic [15:0] crc;
  } crc_state_s;

  crc_state_s  cur;
  crc_state_s  next_cur;
  logic [15:0] work;

  // Clear together with valid starts a new sum with that byte
  always_comb begin
    work     = port.clear ? CRC_INIT : cur.crc;
    next_cur = cur;
    if (port.valid) begin
      work = work ^ {8'h00, port.data};
      for (int i = 0; i < 8; i++) begin
        work = work[0] ? ((work >> 1) ^ CRC_POLY) : (work >> 1);
      end
    end
    next_cur.crc = work;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign port.crc = cur.crc;
endmodule

// ---- verilog/fieldbus_control_word_decoder.sv ----
`timescale 1ns/10ps
module fieldbus_control_word_decoder (
  input  wire logic                                 clk_sys,
  input  wire logic                                 resetn,
  input  wire logic [7:0]                           station_addr,
  input  wire logic [7:0]                           rx_data,
  input  wire logic                                 rx_valid,
  input  wire logic                                 rx_frame_end,
  output logic      [7:0]                           tx_data,
  output logic                                      tx_valid,
  input  wire logic                                 tx_ready,
  input  wire logic [fieldbus_ctl_pkg::DIN_WIDTH-1:0] din_raw,
  input  wire logic [1:0]                           src_ref,
  input  wire logic [1:0]                           src_coast,
  input  wire logic [1:0]                           src_start,
  input  wire logic [1:0]                           src_setup,
  input  wire logic [1:0]                           src_reverse,
  input  wire logic [7:0]                           relay1_func,
  input  wire logic [7:0]                           relay2_func,
  input  wire logic [3:0]                           active_setup,
  output logic      [15:0]                          drive_command_word,
  output logic      [1:0]                           ref_select,
  output logic                                      dc_brake,
  output logic                                      coast,
  output logic                                      quick_stop,
  output logic                                      freq_hold,
  output logic                                      run_enable,
  output logic                                      trip_reset,
  output logic                                      jog,
  output logic                                      ramp_select,
  output logic                                      relay1,
  output logic                                      relay2,
  output logic                                      setup_select,
  output logic                                      reverse
);
  import fieldbus_ctl_pkg::*;

  typedef struct packed {
    link_state_e                          st;
    logic [7:0]                           cnt;
    logic [FRAME_BUF_DEPTH-1:0][7:0]      fb;
    logic [15:0]                          reg_addr;
    logic [7:0]                           hi;
    logic [15:0]                          cand;
    logic                                 cand_hit;
    logic [2:0]                           tx_idx;
    logic [7:0]                           tx_data;
    logic                                 tx_valid;
    logic [15:0]                          word;
    logic [DIN_WIDTH-1:0]                 din_s1;
    logic [DIN_WIDTH-1:0]                 din_s2;
    logic [1:0]                           ref_select;
    logic                                 dc_brake;
    logic                                 coast;
    logic                                 quick_stop;
    logic                                 freq_hold;
    logic                                 run_enable;
    logic                                 trip_reset;
    logic                                 jog;
    logic                                 ramp_select;
    logic                                 relay1;
    logic                                 relay2;
    logic                                 setup_select;
    logic                                 reverse;
  } decoder_s;

  decoder_s    cur;
  decoder_s    next_cur;

  crc_if       rx_crc ();
  crc_if       tx_crc ();

  logic        is_single;
  logic        is_multi;
  logic [15:0] multi_qty;
  logic        frame_ok;
  logic        apply_word;
  logic [15:0] new_word;
  logic        tx_fire;
  logic        in_data_span;
  logic        run_permit;
  logic        start_req;

  // Bus bit and input bit merged as the per-function source select asks
  function automatic logic gate_src(input logic [1:0] sel, input logic bus_b, input logic din_b);
    case (sel)
      SRC_DIGITAL: gate_src = din_b;
      SRC_BUS:     gate_src = bus_b;
      SRC_OR:      gate_src = bus_b | din_b;
      default:     gate_src = bus_b & din_b;
    endcase
  endfunction

  // CRC engines: one checks the query, one builds the multi-write answer
  crc16_engine u_rx_crc (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .port    (rx_crc)
  );

  crc16_engine u_tx_crc (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .port    (tx_crc)
  );

  // Receive sum restarts on the first byte; sending blocks new queries
  assign rx_crc.clear = (cur.st == ST_IDLE);
  assign rx_crc.valid = rx_valid && (cur.st != ST_RESP);
  assign rx_crc.data  = rx_data;
  assign tx_fire      = cur.tx_valid && tx_ready;
  assign tx_crc.clear = (cur.st != ST_RESP);
  assign tx_crc.valid = tx_fire && (cur.tx_idx < POS_RESP_CRC_LO);
  assign tx_crc.data  = cur.tx_data;

  // Frame qualification at the end of a query
  always_comb begin
    is_single    = (cur.fb[1] == FC_PRESET_SINGLE);
    is_multi     = (cur.fb[1] == FC_PRESET_MULTI);
    multi_qty    = {cur.fb[4], cur.fb[5]};
    frame_ok     = 1'b0;
    apply_word   = 1'b0;
    new_word     = {cur.fb[4], cur.fb[5]};
    in_data_span = ({1'b0, cur.cnt} >= {1'b0, POS_MULTI_DATA}) &&
                   ({1'b0, cur.cnt} < ({1'b0, POS_MULTI_DATA} + {1'b0, cur.fb[6]}));
    if ((cur.fb[0] == station_addr || cur.fb[0] == BROADCAST_ADDR) &&
        rx_crc.crc == 16'h0000) begin
      if (is_single) begin
        frame_ok   = (cur.cnt == SINGLE_FRAME_LEN);
        apply_word = frame_ok && ({cur.fb[2], cur.fb[3]} == CMD_WIRE_ADDR);
      end else if (is_multi) begin
        frame_ok   = (multi_qty != 16'h0000) && (multi_qty <= {8'h00, MAX_MULTI_QTY}) &&
                     (cur.fb[6] == {multi_qty[6:0], 1'b0}) &&
                     ({1'b0, cur.cnt} == MULTI_FIXED_LEN + {1'b0, cur.fb[6]});
        apply_word = frame_ok && cur.cand_hit;
        new_word   = cur.cand;
      end
    end
  end

  // Command word to drive functions; inputs pass two flops first
  always_comb begin
    run_permit = gate_src(src_coast, cur.word[BIT_COAST], cur.din_s2[DIN_RUN_PERMIT]) &&
                 !cur.din_s2[DIN_COAST_STOP] && !cur.din_s2[DIN_RST_COAST];
    start_req  = gate_src(src_start, cur.word[BIT_START], cur.din_s2[DIN_START]);
  end

  always_comb begin
    next_cur        = cur;
    next_cur.din_s1 = din_raw;
    next_cur.din_s2 = cur.din_s1;
    next_cur.trip_reset = 1'b0;

    case (cur.st)
      ST_IDLE, ST_RECV: begin
        if (rx_valid) begin
          next_cur.st = ST_RECV;
          if (cur.cnt < 8'(FRAME_BUF_DEPTH)) begin
            next_cur.fb[cur.cnt[2:0]] = rx_data;
          end
          if (cur.cnt != 8'hFF) begin
            next_cur.cnt = cur.cnt + 8'h01;
          end
          // Multi write: walk data pairs, keep the command register's value
          if (cur.cnt == POS_ADDR_LO) begin
            next_cur.reg_addr = {cur.fb[2], rx_data};
          end
          if (is_multi && in_data_span) begin
            if (cur.cnt[0]) begin
              next_cur.hi = rx_data;
            end else begin
              if (cur.reg_addr == CMD_WIRE_ADDR) begin
                next_cur.cand     = {cur.hi, rx_data};
                next_cur.cand_hit = 1'b1;
              end
              next_cur.reg_addr = cur.reg_addr + 16'h0001;
            end
          end
        end else if (rx_frame_end && cur.st == ST_RECV) begin
          next_cur.st       = ST_IDLE;
          next_cur.cnt      = 8'h00;
          next_cur.cand_hit = 1'b0;
          // Data-valid low leaves the previous word in force
          if (apply_word && new_word[BIT_VALID]) begin
            next_cur.word       = new_word;
            next_cur.trip_reset = new_word[BIT_RESET] && !cur.word[BIT_RESET];
          end
          // Broadcast writes are applied but never answered
          if (frame_ok && cur.fb[0] != BROADCAST_ADDR) begin
            next_cur.st       = ST_RESP;
            next_cur.tx_idx   = 3'h0;
            next_cur.tx_data  = cur.fb[0];
            next_cur.tx_valid = 1'b1;
          end
        end
      end
      ST_RESP: begin
        if (tx_fire) begin
          if (cur.tx_idx == POS_RESP_LAST) begin
            next_cur.st       = ST_IDLE;
            next_cur.tx_valid = 1'b0;
          end else if (is_single || cur.tx_idx < POS_RESP_CRC_LO - 3'h1) begin
            next_cur.tx_idx  = cur.tx_idx + 3'h1;
            next_cur.tx_data = cur.fb[cur.tx_idx + 3'h1];
          end else if (cur.tx_idx == POS_RESP_CRC_LO - 3'h1) begin
            // One idle cycle lets the answer CRC absorb the last header byte
            next_cur.tx_idx   = POS_RESP_CRC_LO;
            next_cur.tx_valid = 1'b0;
          end else begin
            next_cur.tx_idx  = POS_RESP_LAST;
            next_cur.tx_data = tx_crc.crc[15:8];
          end
        end else if (!cur.tx_valid) begin
          next_cur.tx_data  = tx_crc.crc[7:0];
          next_cur.tx_valid = 1'b1;
        end
      end
      default: begin
        next_cur.st = ST_IDLE;
      end
    endcase

    // Drive function outputs, one cycle behind the word
    next_cur.freq_hold   = !cur.word[BIT_HOLD];
    next_cur.ref_select  = {gate_src(src_ref, cur.word[BIT_REF_MSB], cur.din_s2[DIN_REF_MSB]),
                            gate_src(src_ref, cur.word[BIT_REF_LSB],
                                     cur.din_s2[DIN_REF_LSB])};
    next_cur.dc_brake    = !cur.word[BIT_DC_BRAKE] || cur.din_s2[DIN_DC_BRAKE];
    next_cur.coast       = !run_permit;
    // A frozen output ignores quick stop and start/stop; only coast and brake act
    next_cur.quick_stop  = !cur.word[BIT_QSTOP] && cur.word[BIT_HOLD];
    next_cur.run_enable  = run_permit && !next_cur.dc_brake &&
                           (!cur.word[BIT_HOLD] ||
                            (start_req && cur.word[BIT_QSTOP]));
    next_cur.jog         = cur.word[BIT_JOG];
    next_cur.ramp_select = cur.word[BIT_RAMP];
    next_cur.relay1      = cur.word[BIT_RELAY1] && (relay1_func == RELAY1_OPTION);
    next_cur.relay2      = cur.word[BIT_RELAY2] && (relay2_func == RELAY2_OPTION);
    next_cur.setup_select = (active_setup == MULTI_SETUP) &&
                            gate_src(src_setup, cur.word[BIT_SETUP],
                                     cur.din_s2[DIN_SETUP]);
    next_cur.reverse     = gate_src(src_reverse, cur.word[BIT_REVERSE],
                                    cur.din_s2[DIN_REVERSE]);
  end

  // Single state register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cur      <= '0;
      cur.word <= CMD_WORD_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from state flops
  assign tx_data            = cur.tx_data;
  assign tx_valid           = cur.tx_valid;
  assign drive_command_word = cur.word;
  assign ref_select         = cur.ref_select;
  assign dc_brake           = cur.dc_brake;
  assign coast              = cur.coast;
  assign quick_stop         = cur.quick_stop;
  assign freq_hold          = cur.freq_hold;
  assign run_enable         = cur.run_enable;
  assign trip_reset         = cur.trip_reset;
  assign jog                = cur.jog;
  assign ramp_select        = cur.ramp_select;
  assign relay1             = cur.relay1;
  assign relay2             = cur.relay2;
  assign setup_select       = cur.setup_select;
  assign reverse            = cur.reverse;

  // Checks on the design's own outputs
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence bad_frame_end;
    cur.st == ST_RECV && !rx_valid && rx_frame_end && rx_crc.crc != 16'h0000;
  endsequence

  sequence answer_start;
    cur.st == ST_RECV && !rx_valid && rx_frame_end && frame_ok &&
      cur.fb[0] != BROADCAST_ADDR;
  endsequence

  // Multi answer: one idle cycle, then the freshly summed low check byte
  sequence crc_after_gap;
    !tx_valid ##1 tx_valid && tx_data == tx_crc.crc[7:0];
  endsequence

  AST_BAD_CRC_SILENT: assert property (bad_frame_end |=>
      cur.st == ST_IDLE && !tx_valid && $stable(drive_command_word))
    else $error("frame with bad check field was acted on");

  AST_ANSWER_OPENS: assert property (answer_start |=>
      tx_valid && tx_data == $past(cur.fb[0]))
    else $error("answer did not open with station address");

  AST_ECHO_BYTES: assert property (
      tx_fire && is_single && cur.tx_idx < POS_RESP_LAST |=> tx_data == cur.fb[cur.tx_idx])
    else $error("single write answer is not an echo");

  AST_MULTI_CRC_GAP: assert property (
      tx_fire && is_multi && cur.tx_idx == POS_RESP_CRC_LO - 3'h1 |=> crc_after_gap)
    else $error("multi write answer check field misplaced");

  AST_VALID_GATE: assert property ($changed(drive_command_word) |->
      drive_command_word[BIT_VALID])
    else $error("word without data-valid took effect");

  AST_TRIP_EDGE: assert property (trip_reset |->
      drive_command_word[BIT_RESET] && !$past(drive_command_word[BIT_RESET]))
    else $error("trip reset without rising edge");

  AST_RELAY1: assert property (relay1 |->
      $past(drive_command_word[BIT_RELAY1]) && $past(relay1_func) == RELAY1_OPTION)
    else $error("relay 1 energised without option");

  AST_RELAY2: assert property (relay2 |->
      $past(drive_command_word[BIT_RELAY2]) && $past(relay2_func) == RELAY2_OPTION)
    else $error("relay 2 energised without option");

  AST_SETUP: assert property (setup_select |-> $past(active_setup) == MULTI_SETUP)
    else $error("set-up chosen outside multi set-up");

  AST_REF_BUS: assert property ($past(src_ref) == SRC_BUS |->
      ref_select == $past(drive_command_word[BIT_REF_MSB:BIT_REF_LSB]))
    else $error("preset reference not taken from bus");

  AST_BRAKE_STOPS: assert property (!drive_command_word[BIT_DC_BRAKE] |=>
      dc_brake && !run_enable)
    else $error("DC brake bit did not stop the drive");

  // Frozen output keeps running unless coast or brake acts
  AST_HOLD_NO_QSTOP: assert property (freq_hold |->
      !quick_stop && (dc_brake || coast || run_enable))
    else $error("frozen drive stopped by other than coast or brake");

  AST_QSTOP_HALTS: assert property (
      !drive_command_word[BIT_QSTOP] && drive_command_word[BIT_HOLD] |=>
      quick_stop && !run_enable)
    else $error("quick stop bit did not halt the drive");
endmodule

// ---- dv/modbus_master_model.sv ----
`timescale 1ns/10ps
module modbus_master_model (
  input  wire logic       clk_sys,
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  output logic            rx_frame_end,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready
);
  logic [7:0] rsp[$];
  logic       slow;

  // Reflected CRC-16 over the given bytes
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
    end
    return c;
  endfunction

  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_frame_end = 1'b0;
    tx_ready = 1'b0;
    slow = 1'b0;
  end

  // Slow mode takes an answer byte only every other cycle
  always @(negedge clk_sys) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end

  // Every byte taken from the answer is kept for the bench
  always @(posedge clk_sys) begin
    if (tx_valid && tx_ready) begin
      rsp.push_back(tx_data);
    end
  end

  // Query sent whole, CRC low byte first; a bad frame flips one CRC bit
  task automatic send_frame(input logic [7:0] b[$], input logic bad);
    logic [15:0] c;
    c = crc16(b) ^ {15'h0000, bad};
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    rsp.delete();
    foreach (b[i]) begin
      @(negedge clk_sys);
      rx_data = b[i];
      rx_valid = 1'b1;
    end
    @(negedge clk_sys);
    rx_valid = 1'b0;
    rx_data = ~rx_data; // Stale byte never looks valid
    rx_frame_end = 1'b1;
    @(negedge clk_sys);
    rx_frame_end = 1'b0;
  endtask
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  import fieldbus_ctl_pkg::*;
  logic        clk_sys, resetn, rx_valid, rx_frame_end, tx_valid, tx_ready;
  logic [7:0]  rx_data, tx_data, relay1_func, relay2_func, q[$], e[$];
  logic [9:0]  din_raw;
  logic [1:0]  src_ref, src_reverse, ref_select, src_coast, src_start, src_setup;
  logic [3:0]  active_setup;
  logic [15:0] drive_command_word;
  logic        dc_brake, coast, quick_stop, freq_hold, run_enable, trip_reset, jog;
  logic        ramp_select, relay1, relay2, setup_select, reverse;
  int          err_total, n_compared, trips;

  fieldbus_control_word_decoder i_fieldbus_control_word_decoder (
    .clk_sys, .resetn, .station_addr(8'h01), .rx_data, .rx_valid, .rx_frame_end,
    .tx_data, .tx_valid, .tx_ready, .din_raw, .src_ref, .src_coast,
    .src_start, .src_setup, .src_reverse, .relay1_func, .relay2_func,
    .active_setup, .drive_command_word, .ref_select, .dc_brake, .coast, .quick_stop,
    .freq_hold, .run_enable, .trip_reset, .jog, .ramp_select, .relay1, .relay2,
    .setup_select, .reverse);
  modbus_master_model i_modbus_master_model (
    .clk_sys, .rx_data, .rx_valid, .rx_frame_end, .tx_data, .tx_valid, .tx_ready);

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Pulse counter: a steady reset bit must not fire again
  always @(posedge clk_sys) begin
    if (trip_reset === 1'b1) trips++;
  end

  function automatic logic [10:0] dv();
    return {ref_select, dc_brake, coast, freq_hold, jog, ramp_select, relay1, relay2,
            setup_select, reverse};
  endfunction

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Sends a query and compares the whole answer; empty e means no answer
  task automatic xfer(input logic bad);
    logic [15:0] c;
    c = i_modbus_master_model.crc16(e);
    if (e.size() > 0) begin
      e.push_back(c[7:0]);
      e.push_back(c[15:8]);
    end
    i_modbus_master_model.send_frame(q, bad);
    for (int i = 0; i < 60 && i_modbus_master_model.rsp.size() < e.size(); i++)
      @(negedge clk_sys);
    repeat (12) @(negedge clk_sys);
    check("rsp_len", 16'(i_modbus_master_model.rsp.size()), 16'(e.size()));
    foreach (e[i]) begin
      if (i < i_modbus_master_model.rsp.size())
        check("rsp_byte", {8'h00, i_modbus_master_model.rsp[i]}, {8'h00, e[i]});
    end
  endtask

  task automatic w06(input logic [15:0] w, input logic bad);
    q = {8'h01, 8'h06, 8'h00, 8'h0F, w[15:8], w[7:0]};
    e = q;
    if (bad) e.delete();
    xfer(bad);
  endtask

  task automatic s_single();
    w06(16'h067F, 1'b0);
    check("word", drive_command_word, 16'h067F);
    check("outputs", {5'h00, dv()}, 16'h0610);
    check("run_enable", {15'h0000, run_enable}, 16'h0001);
    w06(16'h066F, 1'b0);
    check("qstop_hold", {14'h0000, quick_stop, freq_hold}, 16'h0002);
  endtask

  // Invalid word and corrupt frame both leave the register alone
  task automatic s_refuse();
    w06(16'h0001, 1'b0);
    check("word_ignored", drive_command_word, 16'h066F);
    w06(16'h067F, 1'b1);
    check("word_badcrc", drive_command_word, 16'h066F);
  endtask

  // Slow consumer; second register of the run hits the command word
  task automatic s_multi();
    i_modbus_master_model.slow = 1'b1;
    q = {8'h01, 8'h10, 8'h00, 8'h0E, 8'h00, 8'h02, 8'h04, 8'h12, 8'h34, 8'h06, 8'h7F};
    e = {q[0], q[1], q[2], q[3], q[4], q[5]};
    xfer(1'b0);
    check("word_multi", drive_command_word, 16'h067F);
    q = {8'h01, 8'h10, 8'h00, 8'h0E, 8'h00, 8'h02, 8'h03, 8'h12, 8'h34, 8'h06, 8'h6F};
    e.delete();
    xfer(1'b0);
    check("word_bad_count", drive_command_word, 16'h067F);
    i_modbus_master_model.slow = 1'b0;
  endtask

  // Same word twice: options gate relay 1, set-up and reverse
  task automatic s_bits();
    relay1_func = 8'h24;
    relay2_func = 8'h25;
    active_setup = 4'h9;
    src_reverse = SRC_BUS;
    w06(16'hBD8C, 1'b0);
    check("outputs_on", {5'h00, dv()}, 16'h006F);
    check("frozen_runs", {14'h0000, quick_stop, run_enable}, 16'h0001);
    relay1_func = 8'h00;
    active_setup = 4'h0;
    src_reverse = SRC_DIGITAL;
    w06(16'hBD8C, 1'b0);
    check("outputs_gated", {5'h00, dv()}, 16'h0064);
    check("trip_pulses", 16'(trips), 16'h0001);
    w06(16'h0400, 1'b0);
    check("brake_coast", {13'h0000, dc_brake, coast, run_enable}, 16'h0006);
  endtask

  // Reference bits combined with the inputs by AND, then OR
  task automatic s_gate();
    din_raw = 10'h005;
    src_ref = SRC_AND;
    w06(16'h0403, 1'b0);
    check("ref_and", {14'h0000, ref_select}, 16'h0001);
    check("coast_bus", {15'h0000, coast}, 16'h0001);
    src_ref = SRC_OR;
    src_coast = SRC_OR;
    w06(16'h0402, 1'b0);
    check("ref_or", {14'h0000, ref_select}, 16'h0003);
    check("coast_or", {15'h0000, coast}, 16'h0000);
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Whole run is a few hundred cycles; this cuts a hang short
  initial begin
    #200000;
    err_total++;
    report_and_stop();
  end

  initial begin
    resetn = 1'b0;
    din_raw = 10'h004;
    src_ref = SRC_BUS;
    src_coast = SRC_BUS;
    src_start = SRC_BUS;
    src_setup = SRC_BUS;
    src_reverse = SRC_DIGITAL;
    relay1_func = 8'h00;
    relay2_func = 8'h00;
    active_setup = 4'h0;
    repeat (5) @(negedge clk_sys);
    resetn = 1'b1;
    check("word_reset", drive_command_word, 16'h0000);
    check("tx_valid_reset", {15'h0000, tx_valid}, 16'h0000);
    s_single();
    s_refuse();
    s_multi();
    s_bits();
    s_gate();
    report_and_stop();
  end
endmodule
